//--- src/sacz_defs.svh
// Constants for the setpoint alarm and colour-zone block.
// Assumes a 100 MHz clock; included by the two modules and the testbench, not by the package.
`ifndef SACZ_DEFS_SVH
`define SACZ_DEFS_SVH
`define SACZ_ADDR_SETPOINT_ONE   8'h00
`define SACZ_ADDR_SETPOINT_TWO   8'h04
`define SACZ_ADDR_SETPOINT_THREE 8'h08
`define SACZ_ADDR_SETPOINT_FOUR  8'h0C
`define SACZ_ADDR_READING    8'h10
`define SACZ_ADDR_CONFIG     8'h14
`define SACZ_ADDR_COLORS     8'h18
`define SACZ_ADDR_STATUS     8'h1C
`define SACZ_ADDR_IRQ_STAT   8'h20
`define SACZ_ADDR_IRQ_MASK   8'h24
`define SACZ_ADDR_KEYS       8'h28
`define SACZ_ADDR_VIEW       8'h2C
`define SACZ_CFG_SENSE_LSB   0
`define SACZ_CFG_TRI_BIT     4
`define SACZ_CFG_BRIGHT_LSB  8
`define SACZ_KEY_PROG_BIT    0
`define SACZ_KEY_UP_BIT      1
`define SACZ_KEY_DOWN_BIT    2
`define SACZ_KEY_ENTER_BIT   3
`define SACZ_SENSE_RESET     4'h0
`define SACZ_COLOR_RESET     2'h0
`define SACZ_BRIGHT_RESET    4'hF
`define SACZ_IRQ_RELAY_BIT   0
`define SACZ_IRQ_COLOR_BIT   1
`define SACZ_IRQ_EDIT_BIT    2
`define SACZ_IRQ_LOCK_BIT    3
`define SACZ_CLK_MHZ         100
`define SACZ_DEBOUNCE_US     10
`define SACZ_DEBOUNCE_CYC    (`SACZ_DEBOUNCE_US * `SACZ_CLK_MHZ)
`define SACZ_FLASH_MS        250
`define SACZ_FLASH_CYC       (`SACZ_FLASH_MS * 1000 * `SACZ_CLK_MHZ)
`endif

//--- src/sacz_pkg.sv
// Types shared by the setpoint alarm block and its AXI4-Lite slave.
// Assumes the constants header sits beside it.
package sacz_pkg;
	typedef enum logic [1:0] {SACZ_GREEN = 2'h0, SACZ_ORANGE = 2'h1, SACZ_RED = 2'h2} sacz_color_t;
	// Gray codes along the edit path
	typedef enum logic [3:0] {
		SACZ_RUN   = 4'h0,
		SACZ_SENSE = 4'h1,
		SACZ_CBELOW = 4'h3,
		SACZ_CABOVE = 4'h2
	} sacz_mode_t;
endpackage : sacz_pkg

//--- src/sacz_reg_if.sv
// Bus-side register traffic between the slave and the core.
// Assumes one clock domain.
`timescale 1ns/1ps
interface sacz_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_ok;
	modport core (input wr_en, wr_addr, wr_data, rd_addr, output rd_data, rd_ok);
	modport bus  (output wr_en, wr_addr, wr_data, rd_addr, input rd_data, rd_ok);
endinterface : sacz_reg_if

//--- src/sacz_axil.sv
// AXI4-Lite slave: one write and one read at a time, fixed latency.
// Assumes the core answers reads combinationally from rd_addr.
`timescale 1ns/1ps
`include "sacz_defs.svh"
module sacz_axil
	import sacz_pkg::*;
(
	input  wire logic        clk,           // System clock
	input  wire logic        reset,         // Async reset, high
	input  wire logic [7:0]  s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Response ready
	input  wire logic [7:0]  s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read valid
	input  wire logic        s_axi_rready,  // Read ready
	sacz_reg_if.bus          rb             // Core register port
);
	typedef struct packed {
		logic        aw_h;
		logic        w_h;
		logic [7:0]  aw;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bv;
		logic [1:0]  br;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
	} sacz_axil_st_t;
	sacz_axil_st_t st_reg, st_next;
	logic do_wr;
	logic wr_map;

	assign s_axi_awready = !st_reg.aw_h && !st_reg.bv;
	assign s_axi_wready  = !st_reg.w_h && !st_reg.bv;
	assign s_axi_arready = !st_reg.rv;
	assign do_wr         = st_reg.aw_h && st_reg.w_h;
	// Write decode of its own; the read decode follows the read address
	assign wr_map        = (st_reg.aw[1:0] == 2'h0) && (st_reg.aw <= `SACZ_ADDR_VIEW);
	assign rb.wr_en      = do_wr && (st_reg.ws == 4'hF);
	assign rb.wr_addr    = st_reg.aw;
	assign rb.wr_data    = st_reg.wd;
	assign rb.rd_addr    = s_axi_araddr;
	assign s_axi_bvalid  = st_reg.bv;
	assign s_axi_bresp   = st_reg.br;
	assign s_axi_rvalid  = st_reg.rv;
	assign s_axi_rdata   = st_reg.rd;
	assign s_axi_rresp   = st_reg.rr;

	always_comb
	begin
		st_next = st_reg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			st_next.aw_h = 1'b1;
			st_next.aw   = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			st_next.w_h = 1'b1;
			st_next.wd  = s_axi_wdata;
			st_next.ws  = s_axi_wstrb;
		end
		// Partial strobes are refused; registers are whole words
		if (do_wr)
		begin
			st_next.aw_h = 1'b0;
			st_next.w_h  = 1'b0;
			st_next.bv   = 1'b1;
			st_next.br   = (wr_map && st_reg.ws == 4'hF) ? 2'h0 : 2'h2;
		end
		if (st_reg.bv && s_axi_bready)
			st_next.bv = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			st_next.rv = 1'b1;
			st_next.rd = rb.rd_ok ? rb.rd_data : 32'h0000_0000;
			st_next.rr = rb.rd_ok ? 2'h0 : 2'h2;
		end
		else if (st_reg.rv && s_axi_rready)
			st_next.rv = 1'b0;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule : sacz_axil

//--- src/sacz_top.sv
// Setpoint relays, tricolour zone selection, key edit sequence and strap handling.
// Assumes reading and setpoints are signed counts; keys are one-cycle pulses from bus writes to the keys register.
`timescale 1ns/1ps
`include "sacz_defs.svh"
module sacz_top
	import sacz_pkg::*;
#(
	parameter int WIDTH        = 16,               // Reading and setpoint width
	parameter int DEBOUNCE_CYC = `SACZ_DEBOUNCE_CYC, // Strap stable time
	parameter int FLASH_CYC    = `SACZ_FLASH_CYC   // Half period of the edit flash
)(
	input  wire logic        clk,           // System clock
	input  wire logic        reset,         // Async reset, high
	input  wire logic [7:0]  s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Response ready
	input  wire logic [7:0]  s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read valid
	input  wire logic        s_axi_rready,  // Read ready
	input  wire logic        dim_strap_n,   // Brightness strap, low when tied to common
	input  wire logic        lock_strap_n,  // Lockout strap, low when tied to common
	output logic [3:0]       relay_out,     // Relay energize, one per setpoint
	output logic             bar_red,       // Bar lit red
	output logic             bar_orange,    // Bar lit orange
	output logic             bar_green,     // Bar lit green
	output logic [3:0]       brightness,    // Effective display brightness
	output logic [3:0]       sel_flash,     // Selected sense character flashing
	output logic [3:0]       sel_point,     // Decimal point of selected character
	output logic [2:0]       edit_view,     // 0 run, 1 sense, 2 below prompt, 3..6 above prompts
	output logic             irq            // Interrupt, level high
);
	// Refused at elaboration: bus words carry at most 32 bits
	if (WIDTH < 2 || WIDTH > 32)
	begin : g_width_chk
		$error("sacz_top: WIDTH out of range");
	end
	if (DEBOUNCE_CYC < 1 || FLASH_CYC < 1)
	begin : g_count_chk
		$error("sacz_top: counts must be positive");
	end

	function automatic logic [31:0] sx(input logic [WIDTH-1:0] v);
		sx = 32'(signed'(v));
	endfunction : sx

	typedef struct packed {
		logic [3:0][WIDTH-1:0] sp;
		logic [WIDTH-1:0]      reading;
		logic [3:0]            sense;
		logic                  tri_fit;
		logic [3:0]            bright;
		logic [4:0][1:0]       colors;
		logic [3:0]            irq_stat;
		logic [3:0]            irq_mask;
		sacz_mode_t            mode;
		logic [1:0]            sel;
		logic [3:0]            relay;
		logic [1:0]            color;
		logic [2:0][1:0]       sync;
		logic [1:0]            strap;
		logic [31:0]           db_cnt;
		logic [31:0]           fl_cnt;
		logic                  flash;
	} sacz_st_t;
	sacz_st_t st_reg, st_next;

	sacz_reg_if rb();
	sacz_axil u_axil (
		.clk           (clk),
		.reset         (reset),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.rb            (rb.bus)
	);

	logic             locked;
	logic [3:0]       rel_cmp;
	logic [3:0]       above;
	logic [1:0]       zone_color;
	logic [3:0]       key;
	logic [3:0]       sense_flip;
	logic [3:0]       irq_set;
	logic [2:0]       idx;

	assign locked = st_reg.strap[1];

	// Equal reading does not trip either sense
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			above[i]   = $signed(st_reg.reading) > $signed(st_reg.sp[i]);
			rel_cmp[i] = st_reg.sense[i] ? above[i]
				: ($signed(st_reg.reading) < $signed(st_reg.sp[i]));
		end
	end

	// Highest setpoint passed wins; a later index only loses to a strictly larger value
	always_comb
	begin
		logic [WIDTH-1:0] best;
		logic             hit;
		best       = '0;
		hit        = 1'b0;
		zone_color = st_reg.colors[0];
		for (int i = 0; i < 4; i++)
		begin
			if (above[i] && (!hit || $signed(st_reg.sp[i]) >= $signed(best)))
			begin
				hit        = 1'b1;
				best       = st_reg.sp[i];
				zone_color = st_reg.colors[i+1];
			end
		end
	end

	always_comb
	begin
		rb.rd_ok   = 1'b1;
		rb.rd_data = 32'h0000_0000;
		unique case (rb.rd_addr)
			`SACZ_ADDR_SETPOINT_ONE,
			`SACZ_ADDR_SETPOINT_TWO,
			`SACZ_ADDR_SETPOINT_THREE,
			`SACZ_ADDR_SETPOINT_FOUR: rb.rd_data = sx(st_reg.sp[rb.rd_addr[3:2]]);
			`SACZ_ADDR_READING:  rb.rd_data = sx(st_reg.reading);
			`SACZ_ADDR_CONFIG:   rb.rd_data = {20'h00000, st_reg.bright, 3'h0, st_reg.tri_fit, st_reg.sense};
			`SACZ_ADDR_COLORS:   rb.rd_data = {22'h000000, st_reg.colors};
			`SACZ_ADDR_STATUS:   rb.rd_data = {16'h0000, 1'b0, edit_view, st_reg.strap, st_reg.color,
				st_reg.sel, 2'h0, st_reg.relay};
			`SACZ_ADDR_IRQ_STAT: rb.rd_data = {28'h0000000, st_reg.irq_stat};
			`SACZ_ADDR_IRQ_MASK: rb.rd_data = {28'h0000000, st_reg.irq_mask};
			`SACZ_ADDR_KEYS:     rb.rd_data = 32'h0000_0000;
			`SACZ_ADDR_VIEW:     rb.rd_data = {30'h00000000, st_reg.mode == SACZ_CBELOW ? 2'h0 : 2'h0}
				| {30'h00000000, st_reg.mode == SACZ_RUN ? 2'h0
					: st_reg.mode == SACZ_SENSE ? {1'b0, st_reg.sense[st_reg.sel]}
					: st_reg.mode == SACZ_CBELOW ? st_reg.colors[0] : st_reg.colors[st_reg.sel + 3'h1]};
			default:             rb.rd_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		st_next    = st_reg;
		key        = '0;
		sense_flip = '0;
		irq_set    = '0;
		idx        = st_reg.mode == SACZ_CBELOW ? 3'h0 : 3'(st_reg.sel) + 3'h1;
		st_next.sync = {st_reg.sync[1:0], {~lock_strap_n, ~dim_strap_n}};
		if (st_reg.sync[2] != st_reg.strap)
		begin
			if (st_reg.db_cnt >= 32'(DEBOUNCE_CYC - 1))
			begin
				st_next.strap  = st_reg.sync[2];
				st_next.db_cnt = '0;
				irq_set[`SACZ_IRQ_LOCK_BIT] = st_reg.sync[2][1] != st_reg.strap[1];
			end
			else
				st_next.db_cnt = st_reg.db_cnt + 32'h1;
		end
		else
			st_next.db_cnt = '0;
		if (st_reg.mode == SACZ_RUN)
			st_next.fl_cnt = '0;
		else if (st_reg.fl_cnt >= 32'(FLASH_CYC - 1))
		begin
			st_next.fl_cnt = '0;
			st_next.flash  = !st_reg.flash;
		end
		else
			st_next.fl_cnt = st_reg.fl_cnt + 32'h1;
		if (rb.wr_en)
		begin
			unique case (rb.wr_addr)
				`SACZ_ADDR_SETPOINT_ONE,
				`SACZ_ADDR_SETPOINT_TWO,
				`SACZ_ADDR_SETPOINT_THREE,
				`SACZ_ADDR_SETPOINT_FOUR:
					if (!locked)
						st_next.sp[rb.wr_addr[3:2]] = rb.wr_data[WIDTH-1:0];
				`SACZ_ADDR_READING:  st_next.reading = rb.wr_data[WIDTH-1:0];
				`SACZ_ADDR_CONFIG:
					if (!locked)
					begin
						st_next.sense   = rb.wr_data[`SACZ_CFG_SENSE_LSB +: 4];
						st_next.tri_fit = rb.wr_data[`SACZ_CFG_TRI_BIT];
						st_next.bright  = rb.wr_data[`SACZ_CFG_BRIGHT_LSB +: 4];
					end
				`SACZ_ADDR_COLORS:
					if (!locked)
						for (int i = 0; i < 5; i++)
							st_next.colors[i] = rb.wr_data[2*i +: 2] == 2'h3 ? st_reg.colors[i] : rb.wr_data[2*i +: 2];
				`SACZ_ADDR_IRQ_MASK: st_next.irq_mask = rb.wr_data[3:0];
				`SACZ_ADDR_KEYS:     key = rb.wr_data[3:0];
				default:             ;
			endcase
		end
		unique case (st_reg.mode)
			SACZ_RUN:
				if (key[`SACZ_KEY_ENTER_BIT])
				begin
					st_next.mode = SACZ_SENSE;
					st_next.sel  = 2'h0;
				end
			SACZ_SENSE:
			begin
				if ((key[`SACZ_KEY_UP_BIT] || key[`SACZ_KEY_DOWN_BIT]) && !locked)
					sense_flip[st_reg.sel] = 1'b1;
				st_next.sense = st_next.sense ^ sense_flip;
				if (key[`SACZ_KEY_PROG_BIT])
				begin
					st_next.sel = st_reg.sel + 2'h1;
					if (st_reg.sel == 2'h3)
					begin
						irq_set[`SACZ_IRQ_EDIT_BIT] = !st_reg.tri_fit;
						st_next.mode = st_reg.tri_fit ? SACZ_CBELOW : SACZ_RUN;
					end
				end
			end
			SACZ_CBELOW, SACZ_CABOVE:
			begin
				if (!locked && (key[`SACZ_KEY_UP_BIT] || key[`SACZ_KEY_DOWN_BIT]))
				begin
					// Three codes wrap around
					st_next.colors[idx] = key[`SACZ_KEY_UP_BIT]
						? (st_reg.colors[idx] == SACZ_RED ? SACZ_GREEN : st_reg.colors[idx] + 2'h1)
						: (st_reg.colors[idx] == SACZ_GREEN ? SACZ_RED : st_reg.colors[idx] - 2'h1);
				end
				if (key[`SACZ_KEY_PROG_BIT])
				begin
					st_next.sel  = st_reg.mode == SACZ_CBELOW ? 2'h0 : st_reg.sel + 2'h1;
					st_next.mode = st_reg.mode == SACZ_CBELOW ? SACZ_CABOVE
						: st_reg.sel == 2'h3 ? SACZ_RUN : SACZ_CABOVE;
					irq_set[`SACZ_IRQ_EDIT_BIT] = st_reg.mode == SACZ_CABOVE && st_reg.sel == 2'h3;
				end
			end
			default:
				st_next.mode = SACZ_RUN;
		endcase
		st_next.relay = rel_cmp;
		st_next.color = zone_color;
		irq_set[`SACZ_IRQ_RELAY_BIT] = irq_set[`SACZ_IRQ_RELAY_BIT] | (rel_cmp != st_reg.relay);
		irq_set[`SACZ_IRQ_COLOR_BIT] = st_reg.tri_fit && zone_color != st_reg.color;
		// Set beats a write-one clear in the same cycle
		if (rb.wr_en && rb.wr_addr == `SACZ_ADDR_IRQ_STAT)
			st_next.irq_stat = st_reg.irq_stat & ~rb.wr_data[3:0];
		st_next.irq_stat = st_next.irq_stat | irq_set;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			st_reg        <= '0;
			st_reg.sense  <= `SACZ_SENSE_RESET;
			st_reg.bright <= `SACZ_BRIGHT_RESET;
			st_reg.mode   <= SACZ_RUN;
		end
		else
			st_reg <= st_next;
	end

	assign relay_out  = st_reg.relay;
	// One-hot colour; a mono unit drives only red
	assign bar_red    = !st_reg.tri_fit || st_reg.color == SACZ_RED;
	assign bar_orange = st_reg.tri_fit && st_reg.color == SACZ_ORANGE;
	assign bar_green  = st_reg.tri_fit && st_reg.color == SACZ_GREEN;
	assign brightness = st_reg.strap[0] ? {1'b0, st_reg.bright[3:1]} : st_reg.bright;
	assign sel_point  = st_reg.mode == SACZ_SENSE ? 4'h8 >> st_reg.sel : 4'h0;
	assign sel_flash  = st_reg.flash ? sel_point : 4'h0;
	assign edit_view  = st_reg.mode == SACZ_RUN ? 3'h0 : st_reg.mode == SACZ_SENSE ? 3'h1
		: st_reg.mode == SACZ_CBELOW ? 3'h2 : 3'(st_reg.sel) + 3'h3;
	assign irq        = |(st_reg.irq_stat & st_reg.irq_mask);

	relay_high_a: assert property (@(posedge clk) disable iff (reset)
		(st_reg.sense[0] && $signed(st_reg.reading) > $signed(st_reg.sp[0])) |=> relay_out[0])
		else $error("high sense relay not energized");
	relay_low_a: assert property (@(posedge clk) disable iff (reset)
		(!st_reg.sense[1] && $signed(st_reg.reading) >= $signed(st_reg.sp[1])) |=> !relay_out[1])
		else $error("low sense relay wrongly energized");
	one_color_a: assert property (@(posedge clk) disable iff (reset)
		$onehot({bar_red, bar_orange, bar_green}))
		else $error("bar not in exactly one colour");
	sequence sense_last_s;
		st_reg.mode == SACZ_SENSE && st_reg.sel == 2'h3 && key[`SACZ_KEY_PROG_BIT];
	endsequence
	mono_exit_a: assert property (@(posedge clk) disable iff (reset)
		(sense_last_s and !st_reg.tri_fit) |=> edit_view == 3'h0)
		else $error("mono unit did not exit");
	tri_enter_a: assert property (@(posedge clk) disable iff (reset)
		(sense_last_s and st_reg.tri_fit) |=> edit_view == 3'h2)
		else $error("tri unit did not enter colour edit");
	sel_step_a: assert property (@(posedge clk) disable iff (reset)
		(st_reg.mode == SACZ_SENSE && st_reg.sel != 2'h3 && key[`SACZ_KEY_PROG_BIT])
		|=> st_reg.sel == $past(st_reg.sel) + 2'h1)
		else $error("sense selection did not advance");
	dim_half_a: assert property (@(posedge clk) disable iff (reset)
		st_reg.strap[0] |-> brightness == st_reg.bright >> 1)
		else $error("brightness not halved");
	lock_hold_a: assert property (@(posedge clk) disable iff (reset)
		locked |=> $stable(st_reg.sp) || !$past(locked))
		else $error("setpoint changed under lock");
	below_color_a: assert property (@(posedge clk) disable iff (reset)
		(above == 4'h0) |=> st_reg.color == $past(st_reg.colors[0]))
		else $error("below colour not shown");
	tie_color_a: assert property (@(posedge clk) disable iff (reset)
		(above[3] && st_reg.sp[3] == st_reg.sp[1]
			&& !(above[0] && $signed(st_reg.sp[0]) > $signed(st_reg.sp[3]))
			&& !(above[2] && $signed(st_reg.sp[2]) > $signed(st_reg.sp[3])))
		|-> zone_color == st_reg.colors[4])
		else $error("tie not resolved to highest setpoint");
	sequence color_last_s;
		st_reg.mode == SACZ_CABOVE && st_reg.sel == 2'h3 && key[`SACZ_KEY_PROG_BIT];
	endsequence
	color_exit_a: assert property (@(posedge clk) disable iff (reset)
		color_last_s |=> edit_view == 3'h0)
		else $error("colour edit did not exit");
	color_wrap_a: assert property (@(posedge clk) disable iff (reset)
		(st_reg.mode == SACZ_CBELOW && !locked && key[`SACZ_KEY_UP_BIT] && st_reg.colors[0] == SACZ_RED)
		|=> st_reg.colors[0] == SACZ_GREEN)
		else $error("colour code did not wrap");
	sense_flip_a: assert property (@(posedge clk) disable iff (reset)
		(st_reg.mode == SACZ_SENSE && !locked && key[`SACZ_KEY_UP_BIT])
		|=> st_reg.sense == ($past(st_reg.sense) ^ (4'h1 << $past(st_reg.sel))))
		else $error("sense character did not toggle");
endmodule : sacz_top

//--- testbench/sacz_panel_model.sv
// Rear panel switch model for the two strap pins.
// Assumes each switch closes its pin to common; an open pin sits on the pull-up.
`timescale 1ns/1ps
module sacz_panel_model
(
	dim_close,    // Dim switch closed
	lock_close,   // Lock switch closed
	dim_strap_n,  // Dim pin
	lock_strap_n  // Lock pin
);
	input  wire logic dim_close;
	input  wire logic lock_close;
	output logic      dim_strap_n;
	output logic      lock_strap_n;
	// Open contact never floats: pull-up reads high
	assign dim_strap_n  = !dim_close;
	assign lock_strap_n = !lock_close;
endmodule : sacz_panel_model

//--- testbench/setpoint_alarm_color_zone_tb.sv
// Self-checking bench for the setpoint alarm and colour-zone block.
// Assumes short debounce and flash counts; bus answers are awaited, never timed.
`timescale 1ns/1ps
`include "sacz_defs.svh"
module setpoint_alarm_color_zone_tb
	import sacz_pkg::*;
;
	typedef struct packed {logic [15:0] rdg; logic [3:0] rel; logic [2:0] bar;} sacz_row_t;
	logic        clk = 0, reset = 1, dim_close = 0, lock_close = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb = 4'hF, relay_out, brightness, sel_flash, sel_point;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        dim_strap_n, lock_strap_n, bar_red, bar_orange, bar_green, irq;
	logic [2:0]  edit_view;
	logic [3:0]  fl_or, fl_and;
	int          n_fail = 0, compares = 0;
	// Setpoints 10,20,30,20 with sense 5; 20 is tied between two and four
	sacz_row_t   rows [7] = '{'{16'h0005, 4'hA, 3'h1}, '{16'h000A, 4'hA, 3'h1}, '{16'h000F, 4'hB, 3'h2},
		'{16'h0014, 4'h1, 3'h2}, '{16'h0019, 4'h1, 3'h2}, '{16'h0023, 4'h5, 3'h1}, '{16'hFFFD, 4'hA, 3'h1}};

	sacz_top #(.DEBOUNCE_CYC(4), .FLASH_CYC(4)) u_dut (.*);
	sacz_panel_model u_panel (.*);

	initial forever #5 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// Handshakes judged at the rising edge; each channel released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic b_done;
		b_done = 1'b0;
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid  <= 1;
		s_axi_bready  <= 1;
		while (!b_done)
		begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 0;
			if (s_axi_bvalid)
			begin
				b_done = 1'b1;
				resp   = s_axi_bresp;
			end
		end
		s_axi_bready <= 0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic r_done;
		r_done = 1'b0;
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1;
		s_axi_rready  <= 1;
		while (!r_done)
		begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 0;
			if (s_axi_rvalid)
			begin
				r_done = 1'b1;
				rv     = s_axi_rdata;
				resp   = s_axi_rresp;
			end
		end
		s_axi_rready <= 0;
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic key(input logic [3:0] k);
		wr(`SACZ_ADDR_KEYS, {28'h0, k});
		settle(2);
	endtask : key

	task automatic tally_and_finish();
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 0;
		settle(1);
		chk("brightness", 4'hF, brightness);
		chk("relay_out", 4'h0, relay_out);
		rd(8'h30);
		chk("rresp", 2'h2, resp);
		chk("rdata", 32'h0, rv);
		wr(8'h30, 32'h0);
		chk("bresp", 2'h2, resp);
		wr(`SACZ_ADDR_SETPOINT_ONE, 32'd10);
		wr(`SACZ_ADDR_SETPOINT_TWO, 32'd20);
		wr(`SACZ_ADDR_SETPOINT_THREE, 32'd30);
		wr(`SACZ_ADDR_SETPOINT_FOUR, 32'd20);
		wr(`SACZ_ADDR_COLORS, 32'h124);
		wr(`SACZ_ADDR_CONFIG, 32'h815);
		foreach (rows[i])
		begin
			wr(`SACZ_ADDR_READING, {{16{rows[i].rdg[15]}}, rows[i].rdg});
			settle(2);
			chk("relay_out", rows[i].rel, relay_out);
			chk("bar", rows[i].bar, {bar_red, bar_orange, bar_green});
		end
		// Tricolour walk first, then single colour; only the first unmasks the exit event
		for (int t = 1; t >= 0; t--)
		begin
			wr(`SACZ_ADDR_CONFIG, {20'h0, 4'h8, 3'h0, t[0], 4'h5});
			wr(`SACZ_ADDR_IRQ_MASK, {29'h0, t[0], 2'h0});
			wr(`SACZ_ADDR_IRQ_STAT, 32'hF);
			key(4'h8);
			chk("edit_view", 3'h1, edit_view);
			chk("sel_point", 4'h8, sel_point);
			// Nine samples span both flash phases of four cycles each
			fl_or = 4'h0;
			fl_and = 4'hF;
			repeat (9)
			begin
				settle(1);
				fl_or = fl_or | sel_flash;
				fl_and = fl_and & sel_flash;
			end
			chk("sel_flash", 4'h8, fl_or);
			chk("sel_flash", 4'h0, fl_and);
			key(4'h2);
			rd(`SACZ_ADDR_CONFIG);
			chk("sense", 4'h4, rv[3:0]);
			key(4'h1);
			chk("sel_point", 4'h4, sel_point);
			repeat (3) key(4'h1);
			chk("edit_view", t ? 3'h2 : 3'h0, edit_view);
			if (t)
			begin
				key(4'h4);
				rd(`SACZ_ADDR_COLORS);
				chk("below_color", 2'h2, rv[1:0]);
				key(4'h2);
				rd(`SACZ_ADDR_COLORS);
				chk("below_color", 2'h0, rv[1:0]);
			end
			for (int v = 3; t && v <= 7; v++)
			begin
				key(4'h1);
				chk("edit_view", v % 7, edit_view);
			end
			chk("irq", t[0], irq);
			wr(`SACZ_ADDR_IRQ_STAT, 32'h4);
			settle(2);
			chk("irq", 1'b0, irq);
		end
		@(posedge clk);
		lock_close <= 1;
		settle(12);
		wr(`SACZ_ADDR_CONFIG, 32'h0);
		chk("bresp", 2'h0, resp);
		rd(`SACZ_ADDR_CONFIG);
		chk("config", 32'h804, {20'h0, rv[11:0]});
		key(4'h8);
		chk("edit_view", 3'h1, edit_view);
		key(4'h2);
		rd(`SACZ_ADDR_CONFIG);
		chk("sense", 4'h4, rv[3:0]);
		@(posedge clk);
		dim_close <= 1;
		settle(12);
		chk("brightness", 4'h4, brightness);
		@(posedge clk);
		dim_close <= 0;
		settle(12);
		chk("brightness", 4'h8, brightness);
		// Mid-run reset drops any edit in progress
		@(posedge clk);
		reset <= 1;
		repeat (2) @(posedge clk);
		reset <= 0;
		settle(1);
		chk("edit_view", 3'h0, edit_view);
		chk("brightness", 4'hF, brightness);
		chk("relay_out", 4'h0, relay_out);
		tally_and_finish();
	end
endmodule : setpoint_alarm_color_zone_tb
